// ===== pkg/tdmhw_regs.svh
`ifndef TDMHW_REGS_SVH
`define TDMHW_REGS_SVH
// byte offsets on the register bus
`define TDMHW_OFF_CTRL 6'h00
`define TDMHW_OFF_TIMING 6'h04
`define TDMHW_OFF_RXSEL_A 6'h08
`define TDMHW_OFF_RXSEL_B 6'h0C
`define TDMHW_OFF_TXSEL_A 6'h10
`define TDMHW_OFF_TXSEL_B 6'h14
`define TDMHW_OFF_RXDATA 6'h18
`define TDMHW_OFF_TXDATA 6'h1C
`define TDMHW_OFF_STATUS 6'h20
`define TDMHW_OFF_DMACTL 6'h24
`define TDMHW_OFF_RXBASE 6'h28
`define TDMHW_OFF_TXBASE 6'h2C
`define TDMHW_OFF_DMAPOS 6'h30
// control bits
`define TDMHW_C_EN 0
`define TDMHW_C_SLEEP 1
`define TDMHW_C_CLK_MST 2
`define TDMHW_C_FS_MST 3
`define TDMHW_C_MODE2X 4
`define TDMHW_C_TX_LSB 5
`define TDMHW_C_RX_LSB 6
`define TDMHW_C_FS_EDGE 7
`define TDMHW_C_RX_EDGE 8
`define TDMHW_C_TX_EDGE 9
`define TDMHW_C_RX_FSPOL 10
`define TDMHW_C_FS_OUTPOL 11
// timing fields
`define TDMHW_T_HSLOT 0
`define TDMHW_T_RXOFF 8
`define TDMHW_T_TXOFF 12
`define TDMHW_T_CLKDIV 16
`define TDMHW_T_FSW 24
// dma control fields
`define TDMHW_D_CIRC 2
`define TDMHW_D_SIZE 16
// status bits: rx word a/b, rx half, rx end, tx half, tx end
`define TDMHW_S_RXW 0
`define TDMHW_S_DMA 2
// reset values and writable masks
`define TDMHW_CTRL_RST 32'h0000_0000
`define TDMHW_TIMING_RST 32'h0061_0003
`define TDMHW_CTRL_MASK 32'h0000_0FFF
`define TDMHW_TIMING_MASK 32'h0FFF_FF1F
`define TDMHW_SEL_MASK 32'h9F9F_9F9F
`define TDMHW_DMACTL_MASK 32'h1FFF_000F
`define TDMHW_BASE_MASK 32'hFFFF_FFFC
`endif

// ===== pkg/tdmhw_pkg.sv
`default_nettype none
package tdmhw_pkg;
   typedef enum logic [1:0] {
      DMA_IDLE = 2'b00,
      DMA_ARM = 2'b01,
      DMA_BUSY = 2'b10
   } tdmhw_dma_st_t;
endpackage
`default_nettype wire

// ===== logic/tdmhw_port.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tdmhw_regs.svh"
// Notes on behaviour
// - four link signals: bit clock, frame sync, tx data out, rx data in
// - even slot count up to 64, eight bits per slot
// - four rx and four tx slots selectable per half-frame, others ignored
// - tx data driven only in active tx slots, never while sleeping
// - bit rate and frame rate set by divider and slot count
// - rx and tx dma channels, circular or one-shot
// - dma flags at half-buffer and end of buffer
// - dma buffer up to 32 Kbytes, rx and tx bases independent
// - cpu may read and write samples directly, bypassing dma
// - frame sync driven as master, followed as slave
// - bit clock driven as master, followed as slave
// - master divides core clock; slave tracks external edges
// - 1x or 2x bit clocks per data bit
// - msb or lsb first, separately for tx and rx
// - sync sampled on rising edge when 1, falling when 0
// - rx data sampled on rising edge when 1, falling when 0
// - tx data launched on rising edge when 1, falling when 0
// - rx edge count 2N or 2N-1 in 1x, 2N+2 or 2N+1 in 2x
// - tx edge count 2N when edges match, otherwise 2N-1
// - master sync pulse width and polarity programmable
// - rx sync polarity 1 selects active-low sync
// - two 32-bit holding registers per direction used ping-pong
// - flag raised when rx holding word a or b completes
module tdmhw_port #(
   parameter int EW = 12,
   parameter int BW = 13
)(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_bit_clk,
   output logic o_bit_clk,
   output logic o_bit_clk_oe,
   input wire logic i_frame_sync,
   output logic o_frame_sync,
   output logic o_frame_sync_oe,
   input wire logic i_serial_rx_data,
   output logic o_serial_tx_data,
   output logic o_serial_tx_data_oe,
   output logic o_dma_rx_req,
   output logic [31:0] o_dma_rx_addr,
   output logic [31:0] o_dma_rx_wdata,
   input wire logic i_dma_rx_ack,
   output logic o_dma_tx_req,
   output logic [31:0] o_dma_tx_addr,
   input wire logic [31:0] i_dma_tx_rdata,
   input wire logic i_dma_tx_ack
);
   logic [31:0] ctrl_r, timing_r, dmactl_r, rx_base_r, tx_base_r;
   logic [31:0] sel_r [4];
   logic [31:0] rx_hold_r [2];
   logic [31:0] tx_hold_r [2];
   logic [5:0] status_r;
   logic [31:0] rd_mux, rdata_r;
   logic rd_done_r, wr;
   logic en, sleep, clk_mst, fs_mst, mode2x;
   logic [1:0] per_sh;
   logic [5:0] half_slots;
   logic [EW-1:0] fe, ec_r, ec_nxt, wedge;
   logic signed [EW-1:0] rx_edge_count, tx_edge_count;
   logic [7:0] div_cnt_r;
   logic bclk_r, bclk_prev_r, fs_r, fs_prev_r, edge_ev, edge_rise, sync_edge, fs_trig;
   logic [9:0] rx_pos, tx_pos;
   logic [2:0] rx_sel, tx_sel;
   logic rx_strobe, tx_strobe, rx_last, tx_last, rx_half_r, tx_half_r, tx_oe_r;
   logic [7:0] rx_shift_r, rx_byte_nxt, tx_shift_r, tx_byte;
   logic [1:0] dma_trig, dma_ack, dma_half, dma_end, dma_stop;
   logic [BW-1:0] dma_idx [2];
   logic [31:0] dma_addr_r [2];
   tdmhw_pkg::tdmhw_dma_st_t dma_st [2];

   // edges from sync point to data point, may be -1
   function automatic logic [EW-1:0] rel_of(input logic [EW-1:0] ec,
      input logic signed [EW-1:0] ce, input logic [EW-1:0] fr);
      logic signed [EW:0] d;
      d = $signed({1'b0, ec}) - ce;
      if (d < 0)
      begin
         d = d + $signed({1'b0, fr});
      end
      return d[EW-1:0];
   endfunction

   // {aligned, half, slot in half, bit}
   function automatic logic [9:0] pos_of(input logic [EW-1:0] rel, input logic [1:0] sh,
      input logic [5:0] hs);
      logic [EW-1:0] bi;
      logic [5:0] slot;
      logic hb;
      bi = rel >> sh;
      slot = bi[8:3];
      hb = (slot >= hs);
      pos_of = {((rel & ((EW'(1) << sh) - EW'(1))) == '0), hb,
         hb ? 5'(slot - hs) : slot[4:0], bi[2:0]};
   endfunction

   // {hit, lane}: which of four entries picks this slot
   function automatic logic [2:0] sel_hit(input logic [31:0] s, input logic [4:0] sih);
      sel_hit = 3'h0;
      for (int k = 0; k < 4; k++)
      begin
         if (s[8*k+7] && s[8*k +: 5] == sih)
         begin
            sel_hit = {1'b1, 2'(k)};
         end
      end
   endfunction

   assign en = ctrl_r[`TDMHW_C_EN];
   assign sleep = ctrl_r[`TDMHW_C_SLEEP];
   assign clk_mst = ctrl_r[`TDMHW_C_CLK_MST];
   assign fs_mst = ctrl_r[`TDMHW_C_FS_MST];
   assign mode2x = ctrl_r[`TDMHW_C_MODE2X];
   assign per_sh = mode2x ? 2'h2 : 2'h1;
   assign half_slots = {1'b0, timing_r[`TDMHW_T_HSLOT +: 5]} + 6'h01;
   assign fe = EW'(half_slots) << (3'h4 + 3'(per_sh));
   assign wedge = EW'({1'b0, timing_r[`TDMHW_T_FSW +: 4]} + 5'h01) << per_sh;
   assign rx_edge_count = EW'(int'({timing_r[`TDMHW_T_RXOFF +: 4], 1'b0}) + (mode2x ? 2 : 0)
      - ((ctrl_r[`TDMHW_C_FS_EDGE] == ctrl_r[`TDMHW_C_RX_EDGE]) ? 0 : 1));
   assign tx_edge_count = EW'(int'({timing_r[`TDMHW_T_TXOFF +: 4], 1'b0})
      - ((ctrl_r[`TDMHW_C_FS_EDGE] == ctrl_r[`TDMHW_C_TX_EDGE]) ? 0 : 1));

   // bus: reads take one wait state, writes none
   assign wr = i_avs_write;
   assign o_avs_waitrequest = i_avs_read & ~rd_done_r;
   assign o_avs_readdata = rdata_r;
   always_comb
   begin
      case (i_avs_address)
         `TDMHW_OFF_CTRL: rd_mux = ctrl_r;
         `TDMHW_OFF_TIMING: rd_mux = timing_r;
         `TDMHW_OFF_RXSEL_A: rd_mux = sel_r[0];
         `TDMHW_OFF_RXSEL_B: rd_mux = sel_r[1];
         `TDMHW_OFF_TXSEL_A: rd_mux = sel_r[2];
         `TDMHW_OFF_TXSEL_B: rd_mux = sel_r[3];
         `TDMHW_OFF_RXDATA: rd_mux = rx_hold_r[~rx_half_r];
         `TDMHW_OFF_TXDATA: rd_mux = tx_hold_r[~tx_half_r];
         `TDMHW_OFF_STATUS: rd_mux = {22'h0, rx_half_r, tx_half_r, 2'h0, status_r};
         `TDMHW_OFF_DMACTL: rd_mux = dmactl_r;
         `TDMHW_OFF_RXBASE: rd_mux = rx_base_r;
         `TDMHW_OFF_TXBASE: rd_mux = tx_base_r;
         `TDMHW_OFF_DMAPOS: rd_mux = {3'h0, dma_idx[1], 3'h0, dma_idx[0]};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rd_done_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         rd_done_r <= i_avs_read & ~rd_done_r;
         if (i_avs_read && !rd_done_r)
         begin
            rdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ctrl_r <= `TDMHW_CTRL_RST;
         timing_r <= `TDMHW_TIMING_RST;
         rx_base_r <= 32'h0000_0000;
         tx_base_r <= 32'h0000_0000;
         for (int k = 0; k < 4; k++)
         begin
            sel_r[k] <= 32'h0000_0000;
         end
      end
      else if (wr)
      begin
         case (i_avs_address)
            `TDMHW_OFF_CTRL: ctrl_r <= i_avs_writedata & `TDMHW_CTRL_MASK;
            `TDMHW_OFF_TIMING: timing_r <= i_avs_writedata & `TDMHW_TIMING_MASK;
            `TDMHW_OFF_RXSEL_A: sel_r[0] <= i_avs_writedata & `TDMHW_SEL_MASK;
            `TDMHW_OFF_RXSEL_B: sel_r[1] <= i_avs_writedata & `TDMHW_SEL_MASK;
            `TDMHW_OFF_TXSEL_A: sel_r[2] <= i_avs_writedata & `TDMHW_SEL_MASK;
            `TDMHW_OFF_TXSEL_B: sel_r[3] <= i_avs_writedata & `TDMHW_SEL_MASK;
            `TDMHW_OFF_RXBASE: rx_base_r <= i_avs_writedata & `TDMHW_BASE_MASK;
            `TDMHW_OFF_TXBASE: tx_base_r <= i_avs_writedata & `TDMHW_BASE_MASK;
            default: ;
         endcase
      end
   end

   // run bits are cleared by hardware when a one-shot buffer ends
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         dmactl_r <= 32'h0000_0000;
      end
      else
      begin
         if (wr && i_avs_address == `TDMHW_OFF_DMACTL)
         begin
            dmactl_r <= i_avs_writedata & `TDMHW_DMACTL_MASK;
         end
         else
         begin
            dmactl_r[1:0] <= dmactl_r[1:0] & ~dma_stop;
         end
      end
   end

   // set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         status_r <= 6'h00;
      end
      else
      begin
         status_r <= (status_r & ~((wr && i_avs_address == `TDMHW_OFF_STATUS) ?
            i_avs_writedata[5:0] : 6'h00))
            | {dma_end[1], dma_half[1], dma_end[0], dma_half[0],
               rx_strobe & rx_last & rx_pos[8], rx_strobe & rx_last & ~rx_pos[8]};
      end
   end

   // bit clock: divider as master, edge tracking of the pin as slave
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         div_cnt_r <= 8'h00;
         bclk_r <= 1'b0;
         bclk_prev_r <= 1'b0;
      end
      else
      begin
         bclk_prev_r <= i_bit_clk;
         if (!en || !clk_mst)
         begin
            div_cnt_r <= 8'h00;
            bclk_r <= 1'b0;
         end
         else if (div_cnt_r == timing_r[`TDMHW_T_CLKDIV +: 8])
         begin
            div_cnt_r <= 8'h00;
            bclk_r <= ~bclk_r;
         end
         else
         begin
            div_cnt_r <= div_cnt_r + 8'h01;
         end
      end
   end

   assign edge_ev = en & (clk_mst ? (div_cnt_r == timing_r[`TDMHW_T_CLKDIV +: 8])
      : (i_bit_clk ^ bclk_prev_r));
   assign edge_rise = clk_mst ? ~bclk_r : i_bit_clk;
   assign sync_edge = edge_ev & (edge_rise == ctrl_r[`TDMHW_C_FS_EDGE]);
   assign fs_trig = (i_frame_sync ^ ctrl_r[`TDMHW_C_RX_FSPOL]) & ~fs_prev_r;
   assign o_bit_clk = bclk_r;
   assign o_bit_clk_oe = en & clk_mst;
   assign o_frame_sync = fs_r;
   assign o_frame_sync_oe = en & fs_mst;

   always_comb
   begin
      if (!fs_mst && sync_edge && fs_trig)
      begin
         ec_nxt = '0;
      end
      else if (ec_r >= fe - EW'(1))
      begin
         ec_nxt = '0;
      end
      else
      begin
         ec_nxt = ec_r + EW'(1);
      end
   end

   // frame edge counter; a slave resyncs on each sync trigger
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ec_r <= '0;
         fs_prev_r <= 1'b0;
         fs_r <= 1'b0;
      end
      else if (!en)
      begin
         ec_r <= '0;
         fs_prev_r <= 1'b0;
         fs_r <= ctrl_r[`TDMHW_C_FS_OUTPOL];
      end
      else if (edge_ev)
      begin
         ec_r <= ec_nxt;
         fs_r <= (ec_nxt < wedge) ^ ctrl_r[`TDMHW_C_FS_OUTPOL];
         if (sync_edge)
         begin
            fs_prev_r <= i_frame_sync ^ ctrl_r[`TDMHW_C_RX_FSPOL];
         end
      end
   end

   assign rx_pos = pos_of(rel_of(ec_r, rx_edge_count, fe), per_sh, half_slots);
   assign tx_pos = pos_of(rel_of(ec_r, tx_edge_count, fe), per_sh, half_slots);
   assign rx_sel = sel_hit(sel_r[{1'b0, rx_pos[8]}], rx_pos[7:3]);
   assign tx_sel = sel_hit(sel_r[{1'b1, tx_pos[8]}], tx_pos[7:3]);
   assign rx_strobe = edge_ev & (edge_rise == ctrl_r[`TDMHW_C_RX_EDGE]) & rx_pos[9];
   assign tx_strobe = edge_ev & (edge_rise == ctrl_r[`TDMHW_C_TX_EDGE]) & tx_pos[9];
   assign rx_last = (rx_pos[2:0] == 3'h7) && (rx_pos[7:3] == 5'(half_slots - 6'h01));
   assign tx_last = (tx_pos[2:0] == 3'h7) && (tx_pos[7:3] == 5'(half_slots - 6'h01));
   assign rx_byte_nxt = ctrl_r[`TDMHW_C_RX_LSB] ? {i_serial_rx_data, rx_shift_r[7:1]}
      : {rx_shift_r[6:0], i_serial_rx_data};
   assign tx_byte = tx_hold_r[tx_pos[8]][{tx_sel[1:0], 3'h0} +: 8];

   // rx: half flips as its last bit lands, so the cpu sees the finished word
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rx_shift_r <= 8'h00;
         rx_half_r <= 1'b0;
         rx_hold_r[0] <= 32'h0000_0000;
         rx_hold_r[1] <= 32'h0000_0000;
      end
      else if (rx_strobe)
      begin
         rx_shift_r <= rx_byte_nxt;
         rx_half_r <= rx_pos[8] ^ rx_last;
         if (rx_pos[2:0] == 3'h7 && rx_sel[2])
         begin
            rx_hold_r[rx_pos[8]][{rx_sel[1:0], 3'h0} +: 8] <= rx_byte_nxt;
         end
      end
   end

   // tx: bytes leave msb first from the shift register, reversed for lsb first
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         tx_shift_r <= 8'h00;
         tx_half_r <= 1'b0;
         tx_oe_r <= 1'b0;
         o_serial_tx_data <= 1'b0;
      end
      else if (!en || sleep)
      begin
         tx_oe_r <= 1'b0;
         tx_half_r <= 1'b0;
      end
      else if (tx_strobe)
      begin
         tx_oe_r <= tx_sel[2];
         tx_half_r <= tx_pos[8] ^ tx_last;
         if (tx_pos[2:0] == 3'h0)
         begin
            o_serial_tx_data <= ctrl_r[`TDMHW_C_TX_LSB] ? tx_byte[0] : tx_byte[7];
            tx_shift_r <= ctrl_r[`TDMHW_C_TX_LSB] ? {tx_byte[1], tx_byte[2], tx_byte[3],
               tx_byte[4], tx_byte[5], tx_byte[6], tx_byte[7], 1'b0}
               : {tx_byte[6:0], 1'b0};
         end
         else
         begin
            o_serial_tx_data <= tx_shift_r[7];
            tx_shift_r <= {tx_shift_r[6:0], 1'b0};
         end
      end
   end
   assign o_serial_tx_data_oe = tx_oe_r;

   // the free tx half is written by the cpu or the dma channel
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         tx_hold_r[0] <= 32'h0000_0000;
         tx_hold_r[1] <= 32'h0000_0000;
      end
      else if (o_dma_tx_req && i_dma_tx_ack)
      begin
         tx_hold_r[~tx_half_r] <= i_dma_tx_rdata;
      end
      else if (wr && i_avs_address == `TDMHW_OFF_TXDATA)
      begin
         tx_hold_r[~tx_half_r] <= i_avs_writedata;
      end
   end

   // channel 0 stores rx words, channel 1 fetches tx words, one word per half-frame
   assign dma_trig = {tx_strobe & tx_last, rx_strobe & rx_last};
   assign dma_ack = {i_dma_tx_ack, i_dma_rx_ack};
   for (genvar ch = 0; ch < 2; ch++)
   begin : g_dma
      logic [BW-1:0] size, nxt;
      logic busy_ack;
      assign size = dmactl_r[`TDMHW_D_SIZE +: BW];
      assign nxt = dma_idx[ch] + BW'(1);
      assign busy_ack = (dma_st[ch] == tdmhw_pkg::DMA_BUSY) & dma_ack[ch];
      assign dma_half[ch] = busy_ack & (nxt == (size >> 1));
      assign dma_end[ch] = busy_ack & (nxt == size);
      assign dma_stop[ch] = dma_end[ch] & ~dmactl_r[`TDMHW_D_CIRC + ch];
      always_ff @(posedge i_ref_clk or posedge i_sys_rst)
      begin
         if (i_sys_rst)
         begin
            dma_st[ch] <= tdmhw_pkg::DMA_IDLE;
            dma_idx[ch] <= '0;
            dma_addr_r[ch] <= 32'h0000_0000;
         end
         else if (!dmactl_r[ch])
         begin
            dma_st[ch] <= tdmhw_pkg::DMA_IDLE;
            dma_idx[ch] <= '0;
         end
         else
         begin
            case (dma_st[ch])
               tdmhw_pkg::DMA_IDLE:
               begin
                  if (dma_trig[ch])
                  begin
                     dma_st[ch] <= tdmhw_pkg::DMA_ARM;
                  end
               end
               tdmhw_pkg::DMA_ARM:
               begin
                  dma_st[ch] <= tdmhw_pkg::DMA_BUSY;
                  dma_addr_r[ch] <= (ch == 0 ? rx_base_r : tx_base_r)
                     + 32'({dma_idx[ch], 2'h0});
               end
               tdmhw_pkg::DMA_BUSY:
               begin
                  if (dma_ack[ch])
                  begin
                     dma_st[ch] <= tdmhw_pkg::DMA_IDLE;
                     dma_idx[ch] <= dma_end[ch] ? '0 : nxt;
                  end
               end
               default: dma_st[ch] <= tdmhw_pkg::DMA_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_dma_rx_wdata <= 32'h0000_0000;
      end
      else if (dma_st[0] == tdmhw_pkg::DMA_ARM)
      begin
         o_dma_rx_wdata <= rx_hold_r[~rx_half_r];
      end
   end
   assign o_dma_rx_req = dma_st[0] == tdmhw_pkg::DMA_BUSY;
   assign o_dma_tx_req = dma_st[1] == tdmhw_pkg::DMA_BUSY;
   assign o_dma_rx_addr = dma_addr_r[0];
   assign o_dma_tx_addr = dma_addr_r[1];

   property p_tx_quiet;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      $past(!en || sleep) |-> !o_serial_tx_data_oe;
   endproperty
   a_tx_quiet: assert property (p_tx_quiet) else $error("tx driven while off");
   property p_pins_off;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      !en |-> !o_bit_clk_oe && !o_frame_sync_oe;
   endproperty
   a_pins_off: assert property (p_pins_off) else $error("pin driven while off");
   property p_rd_wait;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read answer not after one wait");
   property p_resync;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      en && !fs_mst && sync_edge && fs_trig |=> ec_r == '0;
   endproperty
   a_resync: assert property (p_resync) else $error("slave frame not resynced");
   property p_ec_range;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      edge_ev |=> ec_r < fe || $changed(timing_r) || $changed(ctrl_r);
   endproperty
   a_ec_range: assert property (p_ec_range) else $error("edge count past frame");
   property p_rxw_flag;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      rx_strobe && rx_last |=> status_r[rx_half_r ^ 1'b1];
   endproperty
   a_rxw_flag: assert property (p_rxw_flag) else $error("rx word flag missing");
   property p_dma_hold;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_dma_rx_req && !i_dma_rx_ack && dmactl_r[0] |=> o_dma_rx_req && $stable(o_dma_rx_addr);
   endproperty
   a_dma_hold: assert property (p_dma_hold) else $error("rx dma request dropped");
   property p_one_shot;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      dma_stop[0] && !wr |=> !dmactl_r[0] ##1 !o_dma_rx_req;
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("one-shot rx dma kept running");
   property p_clk_div;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      en && clk_mst && $changed(bclk_r) && $stable(timing_r) |-> $past(edge_ev);
   endproperty
   a_clk_div: assert property (p_clk_div) else $error("bit clock toggled off count");
endmodule
`default_nettype wire

// ===== tb/tdmhw_peer.sv
`timescale 1ns/1ps
`default_nettype none
// far-side peripheral: follows the device pins when driven, else supplies its own
module tdmhw_peer (
   input wire logic i_ref_clk,
   input wire logic i_bit_clk,
   input wire logic i_bit_clk_oe,
   input wire logic i_frame_sync,
   input wire logic i_frame_sync_oe,
   input wire logic i_tx_data,
   input wire logic i_tx_data_oe,
   output logic o_bit_clk,
   output logic o_frame_sync,
   output logic o_rx_data
);
   logic [5:0] cnt_r = 6'h00;
   logic last_r = 1'b0;
   always @(posedge i_ref_clk)
   begin
      cnt_r <= cnt_r + 6'h01;
      last_r <= o_rx_data;
   end
   assign o_bit_clk = i_bit_clk_oe ? i_bit_clk : cnt_r[1];
   assign o_frame_sync = i_frame_sync_oe ? i_frame_sync : (cnt_r[5:2] == 4'h0);
   // looped data; a released wire toggles so a stale bit cannot pass for data
   assign o_rx_data = i_tx_data_oe ? i_tx_data : ~last_r;
endmodule
`default_nettype wire

// ===== tb/test_tdm_highway_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdmhw_regs.svh"
module test_tdm_highway_serial_port;
   logic clk, rst, rd, wr, wreq, bo, boe, fo, foe, tx, toe, bw, fw, rxw;
   logic rq, tq, ra, ta;
   logic [5:0] addr;
   logic [31:0] wdata, rdata, rxa;
   int err_count, checked;
   tdmhw_port uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_bit_clk(bw), .o_bit_clk(bo), .o_bit_clk_oe(boe),
      .i_frame_sync(fw), .o_frame_sync(fo), .o_frame_sync_oe(foe), .i_serial_rx_data(rxw),
      .o_serial_tx_data(tx), .o_serial_tx_data_oe(toe), .o_dma_rx_req(rq),
      .o_dma_rx_addr(rxa), .o_dma_rx_wdata(), .i_dma_rx_ack(ra), .o_dma_tx_req(tq),
      .o_dma_tx_addr(), .i_dma_tx_rdata(32'h0000_0035), .i_dma_tx_ack(ta));
   tdmhw_peer peer (.i_ref_clk(clk), .i_bit_clk(bo), .i_bit_clk_oe(boe),
      .i_frame_sync(fo), .i_frame_sync_oe(foe), .i_tx_data(tx), .i_tx_data_oe(toe),
      .o_bit_clk(bw), .o_frame_sync(fw), .o_rx_data(rxw));
   always @(posedge clk)
   begin
      ra <= rq & ~ra;
      ta <= tq & ~ta;
   end
   task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      rd <= ~we;
      wr <= we;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // whole frames only, so the count does not depend on where it starts
   task automatic oe_cycles(input logic [31:0] e);
      int n;
      n = 0;
      repeat (640)
      begin
         @(posedge clk);
         n += int'(toe === 1'b1);
      end
      chk("tx oe cycles", e, 32'(n));
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_regs;
      logic [31:0] q;
      bus(1'b0, `TDMHW_OFF_CTRL, 32'h0, q);
      chk("ctrl", `TDMHW_CTRL_RST, q);
      bus(1'b0, `TDMHW_OFF_TIMING, 32'h0, q);
      chk("timing", `TDMHW_TIMING_RST, q);
      bus(1'b0, 6'h3C, 32'h0, q);
      chk("unmapped", 32'h0, q);
   endtask
   task automatic t_roles;
      logic [31:0] q;
      bus(1'b1, `TDMHW_OFF_CTRL, 32'h0000_0001, q);
      // longer than one peer frame, so a slave resync takes place
      repeat (70) @(posedge clk);
      chk("slave oe", 32'h0, {30'h0, boe, foe});
      bus(1'b1, `TDMHW_OFF_CTRL, 32'h0000_000D, q);
      repeat (4) @(posedge clk);
      chk("master oe", 32'h3, {30'h0, boe, foe});
   endtask
   // four slots, one bit per two ref cycles: only slot 0 sends, lsb first out,
   // msb first in, so the looped byte comes back reversed
   task automatic t_loop;
      logic [31:0] q, hit;
      hit = 32'h0;
      // stop first: a divider count above the new divisor would stall for hundreds of cycles
      bus(1'b1, `TDMHW_OFF_CTRL, 32'h0, q);
      bus(1'b1, `TDMHW_OFF_TIMING, 32'h0000_0101, q);
      bus(1'b1, `TDMHW_OFF_RXSEL_A, 32'h0000_0080, q);
      bus(1'b1, `TDMHW_OFF_TXSEL_A, 32'h0000_0080, q);
      bus(1'b1, `TDMHW_OFF_CTRL, 32'h0000_02AD, q);
      repeat (60)
      begin
         bus(1'b1, `TDMHW_OFF_TXDATA, 32'h0000_0035, q);
         bus(1'b0, `TDMHW_OFF_RXDATA, 32'h0, q);
         if (q[7:0] === 8'hAC)
            hit = 32'h1;
      end
      chk("rx lane0", 32'h1, hit);
      bus(1'b0, `TDMHW_OFF_STATUS, 32'h0, q);
      chk("rx word a", 32'h1, {31'h0, q[0]});
      oe_cycles(32'h0000_00A0);
   endtask
   // one-shot rx channel of two words: half and end flags, then the run bit drops
   task automatic t_dma;
      logic [31:0] q;
      bus(1'b1, `TDMHW_OFF_RXBASE, 32'h0000_0100, q);
      bus(1'b1, `TDMHW_OFF_DMACTL, 32'h0002_0001, q);
      repeat (160) @(posedge clk);
      bus(1'b0, `TDMHW_OFF_DMACTL, 32'h0, q);
      chk("dma run", 32'h0002_0000, q);
      bus(1'b0, `TDMHW_OFF_STATUS, 32'h0, q);
      chk("rx dma flags", 32'h3, {30'h0, q[3:2]});
      bus(1'b0, `TDMHW_OFF_DMAPOS, 32'h0, q);
      chk("dma pos", 32'h0, q);
      chk("rx dma addr", 32'h0000_0104, rxa);
   endtask
   task automatic t_sleep;
      logic [31:0] q;
      bus(1'b1, `TDMHW_OFF_CTRL, 32'h0000_02AF, q);
      // oe drops one cycle after sleep is written
      @(posedge clk);
      oe_cycles(32'h0);
      bus(1'b1, `TDMHW_OFF_CTRL, 32'h0, q);
      repeat (4) @(posedge clk);
      chk("off pins", 32'h0, {29'h0, boe, foe, toe});
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #500_000;
      err_count++;
      test_done;
   end
   initial
   begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 6'h00;
      wdata = 32'h0;
      ra = 1'b0;
      ta = 1'b0;
      err_count = 0;
      checked = 0;
      repeat (12) @(posedge clk);
      chk("reset pins", 32'h0, {29'h0, boe, foe, toe});
      rst <= 1'b0;
      t_regs;
      t_roles;
      t_loop;
      t_dma;
      t_sleep;
      test_done;
   end
endmodule
`default_nettype wire
